// ===== logic/wdt_top.sv
`include "wdt_cfg.svh"

// ------------------------------------------------------------------
// Overview of operation
// - counter is eight bits, counting down
// - reset and control write load all ones
// - low six write bits are ignored
// - stopped after reset until first write
// - underflow raises internal reset, then stopped until written
// - never written means never any underflow
// - read gives counter top, flag, source
// - flag set makes halt instruction reset
// - halt-disable flag cleared only by reset
// - fast source underflow after 256 ticks
// - slow source interval uses same count
// - counting continues through wait and stabilise
// - control reads 0x3f after reset
// ------------------------------------------------------------------
module wdt_top
#(
   parameter int DIV_SLOW = `WDT_DIV_SLOW,
   parameter int DIV_FAST = `WDT_DIV_FAST,
   parameter int RST_HOLD = `WDT_RST_HOLD
)
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       clock_halt_instruction,
   output logic            halt_grant,
   output logic            wdt_reset_out,
   output logic            irq
);

   localparam int HW = $clog2(RST_HOLD + 1);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   generate
      if (RST_HOLD < 2)
      begin : g_bad_hold
         $error("wdt_top: reset hold must be at least two cycles");
      end
   endgenerate

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   wdt_pkg::wdt_state_t state_reg;   // sequencing state
   logic [7:0]          cnt_reg;     // watchdog counter
   logic                halt_dis_reg; // sticky halt-disable flag
   logic                src_sel_reg; // count source select
   logic [HW-1:0]       hold_reg;    // reset hold countdown
   logic                tick;        // one-cycle count enable

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   logic wr_ctrl;    // write to control register
   logic wr_en;      // write to interrupt enable
   logic wr_clr;     // write to interrupt clear
   logic running;    // counter may decrement
   logic underflow;  // counter wraps this cycle
   logic bad_halt;   // halt attempted while disabled
   logic [`WDT_IRQ_COUNT-1:0] irq_status; // sticky flags
   logic [`WDT_IRQ_COUNT-1:0] irq_enable; // mask
   logic [`WDT_IRQ_COUNT-1:0] irq_events; // one-cycle sources
   logic [`WDT_IRQ_COUNT-1:0] irq_clear;  // clear mask

   // address decode for writes
   always_comb
   begin
      wr_ctrl = 1'b0;
      wr_en   = 1'b0;
      wr_clr  = 1'b0;
      if (reg_wr && reg_addr == `WDT_ADDR_CTRL)
         wr_ctrl = 1'b1;
      else if (reg_wr && reg_addr == `WDT_ADDR_IRQ_EN)
         wr_en = 1'b1;
      else if (reg_wr && reg_addr == `WDT_ADDR_IRQ_CLR)
         wr_clr = 1'b1;
   end

   // count only in run state; no wait or stop input gates it
   assign running = (state_reg == wdt_pkg::WDT_RUN);

   // wrap from zero on a tick, unless a write reloads first
   assign underflow = running && tick && (cnt_reg == 8'h00) && !wr_ctrl;

   // halt attempt while disabled is an undefined instruction
   assign bad_halt = clock_halt_instruction && halt_dis_reg;

   // ------------------------------------------------------------------
   // count source divider
   // ------------------------------------------------------------------
   wdt_prescaler
   #(
      .DIV_SLOW (DIV_SLOW),
      .DIV_FAST (DIV_FAST)
   )
   u_pre
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (wr_ctrl),
      .enable  (running),
      .src_sel (src_sel_reg),
      .tick    (tick)
   );

   // ------------------------------------------------------------------
   // sequencing: idle until written, run, then reset pulse
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= wdt_pkg::WDT_IDLE;
      else
      begin
         case (state_reg)
            wdt_pkg::WDT_IDLE:
               // a forbidden halt outranks the starting write
               if (bad_halt)
                  state_reg <= wdt_pkg::WDT_RST;
               else if (wr_ctrl)
                  state_reg <= wdt_pkg::WDT_RUN;
            wdt_pkg::WDT_RUN:
               if (underflow || bad_halt)
                  state_reg <= wdt_pkg::WDT_RST;
            wdt_pkg::WDT_RST:
               // after the hold the chip restarts; we go back stopped
               if (hold_reg == HW'(1) && !bad_halt)
                  state_reg <= wdt_pkg::WDT_IDLE;
            default:
               state_reg <= wdt_pkg::WDT_IDLE;
         endcase
      end
   end

   // reset hold countdown; a forbidden halt in the hold starts it over
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         hold_reg <= '0;
      else if (state_reg != wdt_pkg::WDT_RST || bad_halt)
         hold_reg <= HW'(RST_HOLD);
      else if (hold_reg != '0)
         hold_reg <= hold_reg - HW'(1);
   end

   // internal reset level while in the reset state
   assign wdt_reset_out = (state_reg == wdt_pkg::WDT_RST);

   // ------------------------------------------------------------------
   // counter
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cnt_reg <= `WDT_CNT_LOAD;
      else if (wr_ctrl)
         cnt_reg <= `WDT_CNT_LOAD;
      else if (state_reg == wdt_pkg::WDT_RST)
         cnt_reg <= `WDT_CNT_LOAD;
      else if (running && tick)
         cnt_reg <= cnt_reg - 8'h01;
   end

   // ------------------------------------------------------------------
   // control flags
   // ------------------------------------------------------------------
   // halt-disable: software can set it, only reset clears it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         halt_dis_reg <= 1'b0;
      else if (wr_ctrl && reg_wdata[`WDT_BIT_HALT_DIS])
         halt_dis_reg <= 1'b1;
   end

   // count source select follows each control write
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         src_sel_reg <= 1'b0;
      else if (wr_ctrl)
         src_sel_reg <= reg_wdata[`WDT_BIT_SRC_SEL];
   end

   // halt permitted: registered one-cycle grant
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         halt_grant <= 1'b0;
      else
         halt_grant <= clock_halt_instruction && !halt_dis_reg;
   end

   // ------------------------------------------------------------------
   // interrupt flags
   // ------------------------------------------------------------------
   assign irq_events[`WDT_IRQ_UNDERFLOW] = underflow;
   assign irq_events[`WDT_IRQ_BAD_HALT]  = bad_halt;
   assign irq_clear = wr_clr ? reg_wdata[`WDT_IRQ_COUNT-1:0] : '0;

   wdt_irq
   #(
      .N (`WDT_IRQ_COUNT)
   )
   u_irq
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .event_set   (irq_events),
      .clear_mask  (irq_clear),
      .enable_wr   (wr_en),
      .enable_data (reg_wdata[`WDT_IRQ_COUNT-1:0]),
      .status      (irq_status),
      .enable      (irq_enable),
      .irq         (irq)
   );

   // ------------------------------------------------------------------
   // read port: data stand one cycle after the strobe, then zero
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (!reg_rd)
         reg_rdata <= 8'h00;
      else if (reg_addr == `WDT_ADDR_CTRL)
         // top six counter bits land in the low field
         reg_rdata <= {src_sel_reg, halt_dis_reg, cnt_reg[7:2]};
      else if (reg_addr == `WDT_ADDR_IRQ_ST)
         reg_rdata <= 8'(irq_status);
      else if (reg_addr == `WDT_ADDR_IRQ_EN)
         reg_rdata <= 8'(irq_enable);
      else
         // clear register and unmapped addresses read zero
         reg_rdata <= 8'h00;
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   // helper: cycles since the last tick while running
   logic [15:0] gap_cnt;

   // counts cycles between ticks so spacing can be checked
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         gap_cnt <= 16'h0000;
      else if (!running || tick || wr_ctrl)
         gap_cnt <= 16'h0000;
      else
         gap_cnt <= gap_cnt + 16'h0001;
   end

   reload_ff_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_ctrl && !bad_halt && state_reg != wdt_pkg::WDT_RST
      |=> (cnt_reg == `WDT_CNT_LOAD) && running)
      else $error("control write did not reload and start the counter");

   step_down_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      running && tick && !wr_ctrl && cnt_reg != 8'h00 && !bad_halt
      |=> cnt_reg == $past(cnt_reg) - 8'h01)
      else $error("counter did not step down by one on a tick");

   idle_frozen_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      state_reg == wdt_pkg::WDT_IDLE && !wr_ctrl && !bad_halt
      |=> $stable(cnt_reg) && !wdt_reset_out)
      else $error("stopped watchdog changed or reset");

   underflow_rst_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      underflow |=> wdt_reset_out [*2])
      else $error("underflow did not hold internal reset");

   read_layout_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      reg_rd && reg_addr == `WDT_ADDR_CTRL
      |=> reg_rdata == {$past(src_sel_reg), $past(halt_dis_reg),
                        $past(cnt_reg[7:2])})
      else $error("control read layout wrong");

   bad_halt_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      clock_halt_instruction && halt_dis_reg
      |=> wdt_reset_out && !halt_grant)
      else $error("disabled halt did not cause reset");

   flag_sticky_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      halt_dis_reg |=> halt_dis_reg)
      else $error("halt-disable flag cleared without reset");

   tick_spacing_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      tick && !src_sel_reg && $past(running) && !$past(wr_ctrl)
      |-> gap_cnt == 16'(DIV_SLOW - 1))
      else $error("slow tick spacing not the divider length");

   low_bits_ignored_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      wr_ctrl ##1 (reg_rd && reg_addr == `WDT_ADDR_CTRL)
      |=> reg_rdata[5:0] == 6'h3f)
      else $error("written low bits reached the counter");

   cov_underflow_c: cover property (
      @(posedge clk) disable iff (sys_rst) underflow);

   cov_bad_halt_c: cover property (
      @(posedge clk) disable iff (sys_rst) bad_halt);

   cov_kick_c: cover property (
      @(posedge clk) disable iff (sys_rst)
      running && !wr_ctrl ##1 wr_ctrl);

   cov_halt_ok_c: cover property (
      @(posedge clk) disable iff (sys_rst) halt_grant);

endmodule

// ===== shared/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ------------------------------------------------------------------
// register map (byte addresses on the 8-bit register port)
// ------------------------------------------------------------------
`define WDT_ADDR_CTRL    8'h29
`define WDT_ADDR_IRQ_ST  8'h30
`define WDT_ADDR_IRQ_EN  8'h31
`define WDT_ADDR_IRQ_CLR 8'h32

// ------------------------------------------------------------------
// control register fields and reset values
// ------------------------------------------------------------------
`define WDT_BIT_HALT_DIS 6
`define WDT_BIT_SRC_SEL  7
`define WDT_CNT_LOAD     8'hff
`define WDT_CTRL_RESET   8'h3f

// ------------------------------------------------------------------
// interrupt status layout
// ------------------------------------------------------------------
`define WDT_IRQ_UNDERFLOW 0
`define WDT_IRQ_BAD_HALT  1
`define WDT_IRQ_COUNT     2

// ------------------------------------------------------------------
// timing counts in system clock cycles
// ------------------------------------------------------------------
`define WDT_DIV_SLOW 512
`define WDT_DIV_FAST 16
`define WDT_RST_HOLD 16

`endif

// ===== shared/wdt_pkg.sv
package wdt_pkg;

   // watchdog sequencing states
   typedef enum logic [1:0]
   {
      WDT_IDLE = 2'b00,  // stopped since reset
      WDT_RUN  = 2'b01,  // counting down
      WDT_RST  = 2'b10   // driving internal reset
   } wdt_state_t;

endpackage

// ===== logic/wdt_prescaler.sv
`include "wdt_cfg.svh"

// count-source divider: one-cycle tick every DIV_SLOW or DIV_FAST cycles
module wdt_prescaler
#(
   parameter int DIV_SLOW = `WDT_DIV_SLOW,
   parameter int DIV_FAST = `WDT_DIV_FAST
)
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic clear,
   input  wire logic enable,
   input  wire logic src_sel,
   output logic      tick
);

   localparam int W = $clog2(DIV_SLOW);

   // ------------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------------
   generate
      if (DIV_FAST < 2 || DIV_SLOW < DIV_FAST)
      begin : g_bad_div
         $error("wdt_prescaler: dividers must satisfy 2 <= fast <= slow");
      end
   endgenerate

   logic [W-1:0] div_reg;   // running phase
   logic [W-1:0] div_last;  // terminal phase for the chosen source

   // source select picks the terminal phase
   assign div_last = src_sel ? W'(DIV_FAST - 1) : W'(DIV_SLOW - 1);

   // tick is a pure decode so it lines up with the wrap
   assign tick = enable && (div_reg == div_last);

   // ------------------------------------------------------------------
   // divider; cleared with the counter so every interval starts whole
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         div_reg <= '0;
      else if (clear || !enable)
         div_reg <= '0;
      else if (div_reg >= div_last)
         div_reg <= '0;
      else
         div_reg <= div_reg + W'(1);
   end

endmodule

// ===== logic/wdt_irq.sv
`include "wdt_cfg.svh"

// sticky event flags, enable mask and write-one-to-clear
module wdt_irq
#(
   parameter int N = `WDT_IRQ_COUNT
)
(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [N-1:0] event_set,
   input  wire logic [N-1:0] clear_mask,
   input  wire logic         enable_wr,
   input  wire logic [N-1:0] enable_data,
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);

   generate
      if (N < 1 || N > 8)
      begin : g_bad_n
         $error("wdt_irq: event count must be 1 to 8");
      end
   endgenerate

   // ------------------------------------------------------------------
   // one sticky flag per event; a set in the clear cycle survives
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_flag
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               status[i] <= 1'b0;
            else if (event_set[i])
               status[i] <= 1'b1;
            else if (clear_mask[i])
               status[i] <= 1'b0;
         end
      end
   endgenerate

   // enable mask, plain read/write
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         enable <= '0;
      else if (enable_wr)
         enable <= enable_data;
   end

   // level output while any enabled flag stands
   assign irq = |(status & enable);

endmodule

// ===== bench/wdt_tb.sv
`include "wdt_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // shortened counts; every expectation derives from these
   // ------------------------------------------------------------
   localparam int DS = 8;  // slow source divide
   localparam int DF = 4;  // fast source divide
   localparam int RH = 2;  // internal reset hold

   logic        clk;                     // system clock, 40 ns
   logic        sys_rst;                 // async chip reset
   logic [7:0]  reg_addr;                // register address
   logic [7:0]  reg_wdata;               // write data
   logic        reg_wr;                  // write strobe
   logic        reg_rd;                  // read strobe
   logic [7:0]  reg_rdata;               // read data, one cycle
   logic        clock_halt_instruction;  // halt request pulse
   logic        halt_grant;              // halt allowed
   logic        wdt_reset_out;           // internal reset request
   logic        irq;                     // level interrupt
   int          failures;                // mismatches
   int          samples_checked;         // comparisons made
   logic [31:0] rng_state;               // xorshift state
   logic [7:0]  rd_val;                  // last read result
   int          exp_src;                 // model: source select
   int          exp_flag;                // model: halt-disable flag
   int          n;                       // cycle counter

   wdt_top #(.DIV_SLOW(DS), .DIV_FAST(DF), .RST_HOLD(RH)) wdt_top_inst
   (
      .clk                    (clk),
      .sys_rst                (sys_rst),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .clock_halt_instruction (clock_halt_instruction),
      .halt_grant             (halt_grant),
      .wdt_reset_out          (wdt_reset_out),
      .irq                    (irq)
   );

   // clock generator
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // next pseudo-random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      t = t ^ (t << 5);
      return t;
   endfunction

   // expected control read from model bits
   function automatic logic [7:0] ctrl_exp(input int cnt6);
      return {exp_src[0], exp_flag[0], cnt6[5:0]};
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // one-cycle write; a fresh edge is awaited on entry, so no double drive
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   // one-cycle read; data stands only in the following cycle
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      rd_val = reg_rdata;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
      rd(a);
      check(name, rd_val, e);
   endtask

   // settled look at the interrupt line
   task automatic irq_chk(input logic e);
      @(negedge clk);
      check("irq", irq, e);
   endtask

   // span with no internal reset at all
   task automatic wait_quiet(input int cycles);
      int hits;
      hits = 0;
      repeat (cycles)
      begin
         @(negedge clk);
         if (wdt_reset_out !== 1'b0) hits++;
      end
      check("quiet span", hits, 0);
   endtask

   // length of the internal reset pulse, from a cycle where it is high
   task automatic hold_chk();
      n = 0;
      while (wdt_reset_out === 1'b1 && n < 100)
      begin
         n++;
         @(negedge clk);
      end
      check("reset hold", n, RH);
   endtask

   // time from the last control write to the internal reset
   task automatic underflow_chk(input int div);
      n = 0;
      while (wdt_reset_out !== 1'b1 && n < 300 * div)
      begin
         @(negedge clk);
         n++;
      end
      check("underflow time", (n >= 256 * div - 4) && (n <= 256 * div + 4), 1);
      hold_chk();
   endtask

   // halt request pulse, answer looked at in the next cycle
   task automatic halt(input logic grant, input logic rst);
      @(posedge clk);
      clock_halt_instruction <= 1'b1;
      @(posedge clk);
      clock_halt_instruction <= 1'b0;
      @(negedge clk);
      check("halt grant", halt_grant, grant);
      check("halt reset", wdt_reset_out, rst);
   endtask

   // the one place where the run ends
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard, well beyond the expected 13k cycles
   initial
   begin
      #(60000 * 40);
      failures++;
      conclude();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      failures = 0;
      samples_checked = 0;
      rng_state = 32'hbfca;
      exp_src = 0;
      exp_flag = 0;
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      clock_halt_instruction = 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, unmapped place reads zero
      rd_chk("ctrl reset", `WDT_ADDR_CTRL, 8'h3f);
      rd_chk("status reset", `WDT_ADDR_IRQ_ST, 8'h00);
      rd_chk("enable reset", `WDT_ADDR_IRQ_EN, 8'h00);
      rd_chk("unmapped", 8'h77, 8'h00);
      // never written: counter must stay put
      wait_quiet(300 * DS);
      rd_chk("ctrl idle", `WDT_ADDR_CTRL, ctrl_exp(63));
      // start with junk in the low bits, then sample mid-count
      rng_state = xs(rng_state);
      wr(`WDT_ADDR_CTRL, {2'b00, rng_state[5:0]});
      rd_chk("ctrl load", `WDT_ADDR_CTRL, ctrl_exp(63));
      // read lands mid-way between top-bit steps, tolerant of one tick
      repeat (22 * DS - 6) @(posedge clk);
      rd_chk("ctrl count", `WDT_ADDR_CTRL, ctrl_exp(58));
      // periodic service keeps the reset away
      repeat (3)
      begin
         wait_quiet(200 * DS);
         rng_state = xs(rng_state);
         wr(`WDT_ADDR_CTRL, {2'b00, rng_state[5:0]});
      end
      underflow_chk(DS);
      // underflow event: sticky, masked, cleared
      rd_chk("status underflow", `WDT_ADDR_IRQ_ST, 8'h01);
      irq_chk(1'b0);
      wr(`WDT_ADDR_IRQ_EN, 8'h01);
      irq_chk(1'b1);
      wr(`WDT_ADDR_IRQ_EN, 8'h00);
      irq_chk(1'b0);
      wr(`WDT_ADDR_IRQ_EN, 8'h03);
      wr(`WDT_ADDR_IRQ_CLR, 8'h01);
      irq_chk(1'b0);
      rd_chk("status cleared", `WDT_ADDR_IRQ_ST, 8'h00);
      rd_chk("clear reads zero", `WDT_ADDR_IRQ_CLR, 8'h00);
      // after the internal reset the counter is stopped again
      rd_chk("ctrl after underflow", `WDT_ADDR_CTRL, ctrl_exp(63));
      wait_quiet(300 * DS);
      // fast source
      exp_src = 1;
      rng_state = xs(rng_state);
      wr(`WDT_ADDR_CTRL, {2'b10, rng_state[5:0]});
      underflow_chk(DF);
      rd_chk("ctrl fast", `WDT_ADDR_CTRL, ctrl_exp(63));
      irq_chk(1'b1);
      wr(`WDT_ADDR_IRQ_CLR, 8'h03);
      // halt allowed while the flag is clear
      halt(1'b1, 1'b0);
      // flag is set-only
      exp_src = 0;
      exp_flag = 1;
      wr(`WDT_ADDR_CTRL, 8'h40);
      rd_chk("flag set", `WDT_ADDR_CTRL, ctrl_exp(63));
      wr(`WDT_ADDR_CTRL, 8'h00);
      rd_chk("flag kept", `WDT_ADDR_CTRL, ctrl_exp(63));
      // halt now forbidden: internal reset and event
      halt(1'b0, 1'b1);
      hold_chk();
      rd_chk("status bad halt", `WDT_ADDR_IRQ_ST, 8'h02);
      irq_chk(1'b1);
      // only chip reset clears the flag
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      exp_flag = 0;
      rd_chk("ctrl rereset", `WDT_ADDR_CTRL, ctrl_exp(63));
      rd_chk("enable rereset", `WDT_ADDR_IRQ_EN, 8'h00);
      conclude();
   end
endmodule
